// ---- rtl/brrp_pkg.sv ----
// Purpose: Shared constants and carriers for the retry and reply-validation policy block
// Assumes: AXI4-Lite slave with 32-bit data, one aligned word per register
// Notes: Configuration register holds 16 bits in the low half of the word
package brrp_pkg;

	// Register map, byte addresses
	localparam logic [7:0] BRRP_CFG_OFFS = 8'h08;
	localparam logic [7:0] BRRP_CTRL_OFFS = 8'h00;
	localparam logic [7:0] BRRP_STAT_OFFS = 8'h04;
	localparam logic [7:0] BRRP_RES_OFFS = 8'h0C;
	localparam logic [15:0] BRRP_CFG_RESET = 16'h0000;

	// Configuration field positions
	localparam int BRRP_STATUS_RETRY_BIT = 9;
	localparam int BRRP_ALT1_BIT = 8;
	localparam int BRRP_ALT2_BIT = 7;
	localparam int BRRP_MEROK_BIT = 6;
	localparam int BRRP_BUSYOK_BIT = 5;

	// Control register field positions
	localparam int BRRP_RETRY_EN_BIT = 0;
	localparam int BRRP_DBL_BIT = 3;

	// Status word flag positions
	localparam int BRRP_SW_MSGERR_BIT = 10;
	localparam int BRRP_SW_BUSY_BIT = 3;
	localparam logic [15:0] BRRP_SW_FLAG_MASK = 16'h071F;

	// AXI responses
	localparam logic [1:0] BRRP_RESP_OKAY = 2'h0;
	localparam logic [1:0] BRRP_RESP_SLVERR = 2'h2;

	// Message outcome presented for evaluation
	typedef struct packed {
		logic [15:0] status_word;
		logic [5:0] words_expected;
		logic [5:0] words_received;
		logic orig_bus_b;
		logic [1:0] attempt;
		logic other_failure;
	} brrp_msg_t;

	// Decision returned for that outcome
	typedef struct packed {
		logic reply_valid;
		logic retry;
		logic retry_bus_b;
		logic retry_second;
	} brrp_dec_t;

endpackage : brrp_pkg

// ---- rtl/brrp_policy.sv ----
// Purpose: Retry and reply-validation policy of a dual-redundant bus controller
// Assumes: Retry engine presents one message outcome per eval pulse
// Notes: One answer per evaluation, two cycles after the pulse is taken
// Functional notes
// - Status-retry bit clear: a status flag alone never causes a retry.
// - Status-retry bit set with retries on: any status flag causes a retry.
// - First retry uses original bus, or opposite bus when first-alternate set.
// - Second retry uses original bus, or opposite bus when second-alternate set.
// - Second retry only when double-retry enable set; else no second retry.
// - Message-error reply valid by default only with full data word count.
// - Message-error short-reply bit also accepts zero following data words.
// - Busy reply valid by default only with full data word count.
// - Busy short-reply bit also accepts zero following data words.
`timescale 1ns/1ps
module brrp_policy (
	// Clock and reset
	input wire logic aclk,
	input wire logic aresetn,
	// Register bus, write side
	input wire logic [7:0] s_axi_awaddr,
	input wire logic s_axi_awvalid,
	output logic s_axi_awready,
	input wire logic [31:0] s_axi_wdata,
	input wire logic [3:0] s_axi_wstrb,
	input wire logic s_axi_wvalid,
	output logic s_axi_wready,
	output logic [1:0] s_axi_bresp,
	output logic s_axi_bvalid,
	input wire logic s_axi_bready,
	// Register bus, read side
	input wire logic [7:0] s_axi_araddr,
	input wire logic s_axi_arvalid,
	output logic s_axi_arready,
	output logic [31:0] s_axi_rdata,
	output logic [1:0] s_axi_rresp,
	output logic s_axi_rvalid,
	input wire logic s_axi_rready,
	// Message outcome in, decision out
	input wire logic eval,
	input wire brrp_pkg::brrp_msg_t msg,
	output brrp_pkg::brrp_dec_t dec,
	output logic dec_valid
);

	// Configuration and control registers
	logic [15:0] cfg_ff;
	logic [1:0] ctrl_ff;
	logic [15:0] nxt_cfg;
	logic [1:0] nxt_ctrl;
	// Write channel state
	logic [7:0] awaddr_ff;
	logic aw_have_ff;
	logic [31:0] wdata_ff;
	logic [3:0] wstrb_ff;
	logic w_have_ff;
	logic awready_ff;
	logic wready_ff;
	logic bvalid_ff;
	logic [1:0] bresp_ff;
	// Read channel state
	logic arready_ff;
	logic rvalid_ff;
	logic [31:0] rdata_ff;
	logic [1:0] rresp_ff;
	// Evaluation pipeline
	logic eval_ff;
	brrp_pkg::brrp_msg_t msg_ff;
	brrp_pkg::brrp_dec_t dec_ff;
	logic dec_valid_ff;
	logic [15:0] last_sw_ff;
	logic [7:0] retry_cnt_ff;
	logic [7:0] invalid_cnt_ff;
	brrp_pkg::brrp_dec_t nxt_dec;

	// Byte-lane merge for the configuration register; control takes lane 0 only
	function automatic logic [15:0] lane_merge(input logic [15:0] old_v,
		input logic [31:0] wd, input logic [3:0] ws);
		logic [15:0] r;
		r = old_v;
		if (ws[0]) begin
			r[7:0] = wd[7:0];
		end
		if (ws[1]) begin
			r[15:8] = wd[15:8];
		end
		return r;
	endfunction : lane_merge

	// Known register decode, used on both channels
	function automatic logic addr_hit(input logic [7:0] a);
		return (a == brrp_pkg::BRRP_CFG_OFFS) || (a == brrp_pkg::BRRP_CTRL_OFFS) ||
			(a == brrp_pkg::BRRP_STAT_OFFS) || (a == brrp_pkg::BRRP_RES_OFFS);
	endfunction : addr_hit

	// A write lands once both halves are held and no response is pending
	logic do_write;
	assign do_write = aw_have_ff && w_have_ff && !bvalid_ff;

	// Address and data are captured independently, in either order
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			aw_have_ff <= 1'b0;
			awaddr_ff <= 8'h00;
			awready_ff <= 1'b0;
		end else if (do_write) begin
			aw_have_ff <= 1'b0;
			awready_ff <= 1'b0;
		end else if (awready_ff && s_axi_awvalid) begin
			aw_have_ff <= 1'b1;
			awaddr_ff <= s_axi_awaddr;
			awready_ff <= 1'b0;
		end else begin
			awready_ff <= !aw_have_ff && !bvalid_ff;
		end
	end

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			w_have_ff <= 1'b0;
			wdata_ff <= 32'h00000000;
			wstrb_ff <= 4'h0;
			wready_ff <= 1'b0;
		end else if (do_write) begin
			w_have_ff <= 1'b0;
			wready_ff <= 1'b0;
		end else if (wready_ff && s_axi_wvalid) begin
			w_have_ff <= 1'b1;
			wdata_ff <= s_axi_wdata;
			wstrb_ff <= s_axi_wstrb;
			wready_ff <= 1'b0;
		end else begin
			wready_ff <= !w_have_ff && !bvalid_ff;
		end
	end

	// Register update; status and reserved words ignore writes
	always_comb begin
		nxt_cfg = cfg_ff;
		nxt_ctrl = ctrl_ff;
		if (do_write && awaddr_ff == brrp_pkg::BRRP_CFG_OFFS) begin
			nxt_cfg = lane_merge(cfg_ff, wdata_ff, wstrb_ff);
		end
		if (do_write && awaddr_ff == brrp_pkg::BRRP_CTRL_OFFS && wstrb_ff[0]) begin
			nxt_ctrl = {wdata_ff[brrp_pkg::BRRP_DBL_BIT], wdata_ff[brrp_pkg::BRRP_RETRY_EN_BIT]};
		end
	end

	// Configuration word, cleared by reset
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			cfg_ff <= brrp_pkg::BRRP_CFG_RESET;
		end else begin
			cfg_ff <= nxt_cfg;
		end
	end

	// Control word; retries stay off until software enables them
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			ctrl_ff <= 2'h0;
		end else begin
			ctrl_ff <= nxt_ctrl;
		end
	end

	// Write response; unmapped addresses answer SLVERR
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			bvalid_ff <= 1'b0;
			bresp_ff <= brrp_pkg::BRRP_RESP_OKAY;
		end else if (do_write) begin
			bvalid_ff <= 1'b1;
			bresp_ff <= addr_hit(awaddr_ff) ? brrp_pkg::BRRP_RESP_OKAY :
				brrp_pkg::BRRP_RESP_SLVERR;
		end else if (s_axi_bready) begin
			bvalid_ff <= 1'b0;
		end
	end

	// Read path: one read under way, answer the cycle after the take
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			arready_ff <= 1'b0;
			rvalid_ff <= 1'b0;
			rdata_ff <= 32'h00000000;
			rresp_ff <= brrp_pkg::BRRP_RESP_OKAY;
		end else if (arready_ff && s_axi_arvalid) begin
			arready_ff <= 1'b0;
			rvalid_ff <= 1'b1;
			rresp_ff <= addr_hit(s_axi_araddr) ? brrp_pkg::BRRP_RESP_OKAY :
				brrp_pkg::BRRP_RESP_SLVERR;
			case (s_axi_araddr)
				brrp_pkg::BRRP_CFG_OFFS: rdata_ff <= {16'h0000, cfg_ff};
				brrp_pkg::BRRP_CTRL_OFFS: rdata_ff <= {28'h0000000, ctrl_ff[1], 2'h0, ctrl_ff[0]};
				brrp_pkg::BRRP_STAT_OFFS: rdata_ff <= {retry_cnt_ff, invalid_cnt_ff, last_sw_ff};
				default: rdata_ff <= 32'h00000000;
			endcase
		end else if (rvalid_ff) begin
			if (s_axi_rready) begin
				rvalid_ff <= 1'b0;
			end
		end else begin
			arready_ff <= 1'b1;
		end
	end

	// Register the outcome first; decision logic is off the input path
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			eval_ff <= 1'b0;
			msg_ff <= '0;
		end else begin
			eval_ff <= eval;
			if (eval) begin
				msg_ff <= msg;
			end
		end
	end

	// Policy decision for the registered outcome
	always_comb begin
		logic sw_flag;
		logic merr;
		logic busy;
		logic full;
		logic none;
		logic ok;
		logic want;
		logic can;
		// Defaults keep every local assigned on every path
		want = 1'b0;
		can = 1'b0;
		sw_flag = |(msg_ff.status_word & brrp_pkg::BRRP_SW_FLAG_MASK);
		merr = msg_ff.status_word[brrp_pkg::BRRP_SW_MSGERR_BIT];
		busy = msg_ff.status_word[brrp_pkg::BRRP_SW_BUSY_BIT];
		full = msg_ff.words_received == msg_ff.words_expected;
		none = msg_ff.words_received == 6'h00;
		ok = full;
		// Short reply is legal only when its own enable covers each set flag
		if (merr && !full) begin
			ok = none && cfg_ff[brrp_pkg::BRRP_MEROK_BIT];
		end
		if (busy && !full) begin
			ok = none && cfg_ff[brrp_pkg::BRRP_BUSYOK_BIT] &&
				(!merr || cfg_ff[brrp_pkg::BRRP_MEROK_BIT]);
		end
		nxt_dec.reply_valid = ok && !msg_ff.other_failure;
		// A flag only counts as a failure when status retry is on
		want = !nxt_dec.reply_valid ||
			(sw_flag && cfg_ff[brrp_pkg::BRRP_STATUS_RETRY_BIT]);
		// Attempt 0 is the original, 1 is the first retry
		can = ctrl_ff[0] && ((msg_ff.attempt == 2'h0) ||
			(msg_ff.attempt == 2'h1 && ctrl_ff[1]));
		nxt_dec.retry = want && can;
		nxt_dec.retry_second = nxt_dec.retry && msg_ff.attempt == 2'h1;
		// Bus is always chosen relative to the original attempt
		nxt_dec.retry_bus_b = msg_ff.orig_bus_b ^ (nxt_dec.retry_second ?
			cfg_ff[brrp_pkg::BRRP_ALT2_BIT] : cfg_ff[brrp_pkg::BRRP_ALT1_BIT]);
	end

	// Decision output; dec holds until the next answer
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			dec_ff <= '0;
			dec_valid_ff <= 1'b0;
		end else begin
			dec_valid_ff <= eval_ff;
			if (eval_ff) begin
				dec_ff <= nxt_dec;
			end
		end
	end

	// Last status word seen, for software to inspect
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			last_sw_ff <= 16'h0000;
		end else if (eval_ff) begin
			last_sw_ff <= msg_ff.status_word;
		end
	end

	// Retry and invalid-reply counters; they wrap rather than saturate
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			retry_cnt_ff <= 8'h00;
			invalid_cnt_ff <= 8'h00;
		end else if (eval_ff) begin
			if (nxt_dec.retry) begin
				retry_cnt_ff <= retry_cnt_ff + 8'h01;
			end
			if (!nxt_dec.reply_valid) begin
				invalid_cnt_ff <= invalid_cnt_ff + 8'h01;
			end
		end
	end

	assign s_axi_awready = awready_ff;
	assign s_axi_wready = wready_ff;
	assign s_axi_bvalid = bvalid_ff;
	assign s_axi_bresp = bresp_ff;
	assign s_axi_arready = arready_ff;
	assign s_axi_rvalid = rvalid_ff;
	assign s_axi_rdata = rdata_ff;
	assign s_axi_rresp = rresp_ff;
	assign dec = dec_ff;
	assign dec_valid = dec_valid_ff;

endmodule : brrp_policy

// ---- verif/brrp_policy_assertions.sv ----
// Purpose: Timing and decision checks on the policy block ports
// Assumes: Configuration unseen, so only its config-free consequences
// Notes: Outcome is delayed two edges to line up with its answer
`timescale 1ns/1ps
module brrp_policy_chk (
	input wire logic aclk,
	input wire logic aresetn,
	input wire logic eval,
	input wire brrp_pkg::brrp_msg_t msg,
	input wire brrp_pkg::brrp_dec_t dec,
	input wire logic dec_valid
);
	brrp_pkg::brrp_msg_t m1_ff;
	brrp_pkg::brrp_msg_t m2_ff;
	logic full;
	logic zero;
	logic flg;
	// Outcome that the current answer belongs to
	always_ff @(posedge aclk) begin
		m1_ff <= msg;
		m2_ff <= m1_ff;
	end
	// Reply shape of that outcome
	assign full = m2_ff.words_received == m2_ff.words_expected;
	assign zero = m2_ff.words_received == 6'h00;
	assign flg = m2_ff.status_word[brrp_pkg::BRRP_SW_MSGERR_BIT] |
		m2_ff.status_word[brrp_pkg::BRRP_SW_BUSY_BIT];
	default clocking cb @(posedge aclk); endclocking
	default disable iff (!aresetn);
	sequence s_answer;
		##2 dec_valid;
	endsequence
	AST_LAT: assert property (eval |-> s_answer)
		else $error("answer not two edges after eval");
	AST_FULL: assert property (dec_valid && full && !m2_ff.other_failure |-> dec.reply_valid)
		else $error("full reply refused");
	AST_OTHER: assert property (dec_valid && m2_ff.other_failure |-> !dec.reply_valid)
		else $error("failed reply accepted");
	AST_PART: assert property (dec_valid && !full && !zero |-> !dec.reply_valid)
		else $error("partial reply accepted");
	AST_NOFLAG: assert property (dec_valid && !full && !flg |-> !dec.reply_valid)
		else $error("short unflagged reply accepted");
	AST_THIRD: assert property (dec_valid && m2_ff.attempt > 2'h1 |-> !dec.retry)
		else $error("third retry");
	AST_CAUSE: assert property (dec_valid && dec.retry && dec.reply_valid
		|-> (m2_ff.status_word & brrp_pkg::BRRP_SW_FLAG_MASK) != 16'h0000)
		else $error("retry without cause");
	AST_SECOND: assert property (dec_valid && dec.retry
		|-> dec.retry_second == (m2_ff.attempt == 2'h1))
		else $error("second retry marker wrong");
endmodule : brrp_policy_chk

// ---- verif/brrp_policy_bench.sv ----
// Purpose: Self-checking bench for the retry and reply policy block
// Assumes: AXI4-Lite master tasks, partner model supplies outcomes
// Notes: Expected decisions worked out from configuration bits
`timescale 1ns/1ps
module brrp_policy_bench;
	logic aclk, aresetn, s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready;
	logic s_axi_bvalid, s_axi_bready, s_axi_arvalid, s_axi_arready, s_axi_rvalid;
	logic s_axi_rready, eval, dec_valid;
	logic [7:0] s_axi_awaddr, s_axi_araddr;
	logic [31:0] s_axi_wdata, s_axi_rdata;
	logic [3:0] s_axi_wstrb;
	logic [1:0] s_axi_bresp, s_axi_rresp;
	brrp_pkg::brrp_msg_t msg;
	brrp_pkg::brrp_dec_t dec;
	int n_errors = 0;
	int tests_run = 0;
	int cyc = 0;
	initial aclk = 1'b0;
	always #20 aclk = ~aclk;
	brrp_policy u_brrp_policy (.aclk, .aresetn, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready,
		.s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid,
		.s_axi_bready, .s_axi_araddr, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata,
		.s_axi_rresp, .s_axi_rvalid, .s_axi_rready, .eval, .msg, .dec, .dec_valid);
	brrp_rt_model u_brrp_rt_model (.aclk, .eval, .msg);
	task give_verdict;
		if (n_errors == 0 && tests_run > 0)
			$display("STATUS OK");
		else
			$display("STATUS NOT OK");
		$finish;
	endtask : give_verdict
	task chk(input logic [31:0] g, input logic [31:0] e);
		tests_run++;
		if (g !== e) begin
			n_errors++;
			$display("mismatch %0t got %h exp %h", $time, g, e);
		end
	endtask : chk
	// Write with address and data offered together, each released when taken
	task axw(input logic [7:0] a, input logic [31:0] v, input logic [1:0] er);
		logic pa, pw;
		@(posedge aclk);
		pa = 1'b1;
		pw = 1'b1;
		s_axi_awaddr <= a;
		s_axi_wdata <= v;
		s_axi_awvalid <= 1'b1;
		s_axi_wvalid <= 1'b1;
		s_axi_bready <= 1'b1;
		while (pa || pw) begin
			@(posedge aclk);
			if (pa && s_axi_awready) begin
				pa = 1'b0;
				s_axi_awvalid <= 1'b0;
			end
			if (pw && s_axi_wready) begin
				pw = 1'b0;
				s_axi_wvalid <= 1'b0;
			end
		end
		do @(posedge aclk); while (!s_axi_bvalid);
		chk({30'h0, s_axi_bresp}, {30'h0, er});
		s_axi_bready <= 1'b0;
	endtask : axw
	task axr(input logic [7:0] a, input logic [31:0] ed, input logic [1:0] er);
		@(posedge aclk);
		s_axi_araddr <= a;
		s_axi_arvalid <= 1'b1;
		s_axi_rready <= 1'b1;
		do @(posedge aclk); while (!s_axi_arready);
		s_axi_arvalid <= 1'b0;
		do @(posedge aclk); while (!s_axi_rvalid);
		chk(s_axi_rdata, ed);
		chk({30'h0, s_axi_rresp}, {30'h0, er});
		s_axi_rready <= 1'b0;
	endtask : axr
	task cfg(input logic [31:0] v);
		axw(brrp_pkg::BRRP_CFG_OFFS, v, 2'h0);
	endtask : cfg
	task ctl(input logic [31:0] v);
		axw(brrp_pkg::BRRP_CTRL_OFFS, v, 2'h0);
	endtask : ctl
	// One outcome of four expected words, answer awaited under a bound
	task ev(input logic [15:0] sw, input logic [5:0] g, input logic b, input logic [1:0] at,
		input logic of, input logic [3:0] e);
		int k;
		u_brrp_rt_model.reply('{sw, 6'h04, g, b, at, of});
		k = 0;
		do begin
			@(posedge aclk);
			k++;
		end while (!dec_valid && k < 8);
		chk(k, 32'h00000002);
		chk({28'h0, dec}, {28'h0, e});
	endtask : ev
	task t_regs;
		axr(brrp_pkg::BRRP_CFG_OFFS, {16'h0, brrp_pkg::BRRP_CFG_RESET}, 2'h0);
		cfg(32'hFFFFFFFF);
		axr(brrp_pkg::BRRP_CFG_OFFS, 32'h0000FFFF, 2'h0);
		// Upper lane only: the low byte keeps its ones
		s_axi_wstrb <= 4'h2;
		cfg(32'h00000000);
		s_axi_wstrb <= 4'hF;
		axr(brrp_pkg::BRRP_CFG_OFFS, 32'h000000FF, 2'h0);
		axr(brrp_pkg::BRRP_RES_OFFS, 32'h00000000, 2'h0);
		axr(8'h10, 32'h0, 2'h2);
		axw(8'h10, 32'h0, 2'h2);
	endtask : t_regs
	task t_status;
		ctl(32'h1);
		cfg(32'h0);
		ev(16'h0008, 6'h04, 1'b0, 2'h0, 1'b0, 4'h8);
		cfg(32'h200);
		ev(16'h0010, 6'h04, 1'b0, 2'h0, 1'b0, 4'hC);
		ev(16'h0000, 6'h04, 1'b0, 2'h0, 1'b0, 4'h8);
		ctl(32'h0);
		ev(16'h0008, 6'h04, 1'b0, 2'h0, 1'b0, 4'h8);
		// One retry, no invalid reply, busy word last
		axr(brrp_pkg::BRRP_STAT_OFFS, 32'h01000008, 2'h0);
	endtask : t_status
	task t_bus;
		ctl(32'h9);
		axr(brrp_pkg::BRRP_CTRL_OFFS, 32'h00000009, 2'h0);
		for (int i = 0; i < 8; i++) begin
			cfg((i[0] ? 32'h100 : 32'h0) | (i[1] ? 32'h80 : 32'h0));
			ev(16'h0, 6'h04, i[2], 2'h0, 1'b1, {2'b01, i[2] ^ i[0], 1'b0});
			ev(16'h0, 6'h04, i[2], 2'h1, 1'b1, {2'b01, i[2] ^ i[1], 1'b1});
		end
		ctl(32'h1);
		cfg(32'h0);
		ev(16'h0, 6'h04, 1'b0, 2'h1, 1'b1, 4'h0);
		ev(16'h0, 6'h04, 1'b0, 2'h2, 1'b1, 4'h0);
	endtask : t_bus
	task t_short;
		ctl(32'h0);
		for (int i = 0; i < 4; i++) begin
			cfg((i[0] ? 32'h40 : 32'h0) | (i[1] ? 32'h20 : 32'h0));
			ev(16'h0400, 6'h00, 1'b0, 2'h0, 1'b0, {i[0], 3'h0});
			ev(16'h0008, 6'h00, 1'b0, 2'h0, 1'b0, {i[1], 3'h0});
			ev(16'h0400, 6'h02, 1'b0, 2'h0, 1'b0, 4'h0);
			ev(16'h0000, 6'h00, 1'b0, 2'h0, 1'b0, 4'h0);
		end
	endtask : t_short
	// Hang guard, far above the few hundred cycles the run needs
	always @(posedge aclk) begin
		cyc++;
		if (cyc == 20000) begin
			n_errors++;
			give_verdict;
		end
	end
	initial begin
		{s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready} = 5'h00;
		{s_axi_awaddr, s_axi_araddr, s_axi_wdata} = '0;
		s_axi_wstrb = 4'hF;
		aresetn = 1'b0;
		repeat (10) @(posedge aclk);
		aresetn <= 1'b1;
		t_regs;
		t_status;
		t_bus;
		t_short;
		give_verdict;
	end
endmodule : brrp_policy_bench
bind brrp_policy brrp_policy_chk u_chk (.aclk(aclk), .aresetn(aresetn), .eval(eval), .msg(msg),
	.dec(dec), .dec_valid(dec_valid));

// ---- verif/brrp_rt_model.sv ----
// Purpose: Remote terminal reply outcome source
// Assumes: One outcome per call, eval one cycle wide
// Notes: Reply content chosen by the caller
`timescale 1ns/1ps
module brrp_rt_model (
	input wire logic aclk,
	output logic eval,
	output brrp_pkg::brrp_msg_t msg
);
	initial begin
		eval = 1'b0;
		msg = '0;
	end
	// Outcome offered right after an edge, pulse dropped one edge later
	task reply(input brrp_pkg::brrp_msg_t m);
		@(posedge aclk);
		msg <= m;
		eval <= 1'b1;
		@(posedge aclk);
		eval <= 1'b0;
	endtask : reply
endmodule : brrp_rt_model
